// ==== fan_pwm_duty_arbitration.v ====
// Behaviour
// R1 - Each output runs near 22.5 kHz; per-channel control selects slower rates.
// R2 - Alternate step mapping selectable at any rate, governs auto and 4-bit fields.
// R3 - Alternate map: 0 off, 1-10 from 25 to 57.14%, 11-13 up to 100%.
// R4 - Final duty is max of forced, ramps, and manual or spin-up/auto.
// R5 - Zone boost, tach limit or override bit force every output full.
// R6 - Regulator hot on an idle ramp captures other request plus one step.
// R7 - While hot and ramp active, add a step each interval, saturating full.
// R8 - When not hot, subtract a step each interval; retire below other request.
// R9 - Capture repeats only after ramp retired; short drops do not restart.
// R10 - Ramp only affects bound outputs; every output owns independent ramps.
// R11 - Processor-hot ramp follows measurement above threshold, down after new one.
// R12 - Each processor-hot input has its own binding to outputs.
// R13 - Manual duty follows software, higher functions may still raise it.
// R14 - Final duty leaving zero starts spin-up duty for programmed time; the code ignores spin-up duty while manual mode is set.
// R15 - Ramp steps use current mapping step size, clamped to duty range.
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_consts.vh"

module fan_pwm_duty_arbitration #(
    parameter NUM_PWM = 2,
    parameter MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata_r,
    // Force-full causes
    input wire [3:0] zone_boost_active,
    input wire tach_limit_exceeded,
    // Regulator hot pins, active low
    input wire [1:0] regulator_hot_input_n,
    // Processor hot measurements and strobes
    input wire [15:0] processor_hot_measure,
    input wire [1:0] processor_hot_new,
    // Auto step codes
    input wire [4*NUM_PWM-1:0] auto_step,
    // Fan power stage drive
    output reg [NUM_PWM-1:0] fan_pwm_output
);

    // ==========================================================
    // Helpers
    function [7:0] max8;
        input [7:0] a;
        input [7:0] b;
        begin
            max8 = (a > b) ? a : b;
        end
    endfunction

    // ==========================================================
    // Global registers and shared timing
    reg [7:0] control_r;
    reg [7:0] ramp_ms_r;
    reg [7:0] phot_limit_r;
    reg [17:0] ms_div_r;
    reg ms_tick_r;
    reg [2:0] vrd_sync0_r;
    reg [2:0] vrd_sync1_r;
    reg [1:0] regulator_hot_input_r;
    reg [1:0] phot_over_r;
    wire force_full;
    wire global_wr;
    wire [NUM_PWM*8-1:0] ch_rd_bus;

    assign global_wr = reg_write && reg_addr[7:4] == 4'h0;

    // Software writes to global registers
    always @(posedge clock) begin
        if (reset) begin
            control_r <= `RST_CONTROL;
            ramp_ms_r <= `RST_RAMP_MS;
            phot_limit_r <= `RST_PHOT_LIMIT;
        end else if (global_wr) begin
            case (reg_addr)
                `REG_CONTROL: control_r <= reg_wdata;
                `REG_RAMP_MS: ramp_ms_r <= reg_wdata;
                `REG_PHOT_LIMIT: phot_limit_r <= reg_wdata;
                default: control_r <= control_r;
            endcase
        end
    end

    // Millisecond enable
    always @(posedge clock) begin
        if (reset) begin
            ms_div_r <= 18'h00000;
            ms_tick_r <= 1'b0;
        end else if (ms_div_r >= MS_CYCLES - 1) begin
            ms_div_r <= 18'h00000;
            ms_tick_r <= 1'b1;
        end else begin
            ms_div_r <= ms_div_r + 18'h00001;
            ms_tick_r <= 1'b0;
        end
    end

    // Pin synchroniser; a level counts once stages two and three agree
    always @(posedge clock) begin
        if (reset) begin
            vrd_sync0_r <= 3'h7;
            vrd_sync1_r <= 3'h7;
            regulator_hot_input_r <= 2'h0;
        end else begin
            vrd_sync0_r <= {vrd_sync0_r[1:0], regulator_hot_input_n[0]};
            vrd_sync1_r <= {vrd_sync1_r[1:0], regulator_hot_input_n[1]};
            if (vrd_sync0_r[1] == vrd_sync0_r[2])
                regulator_hot_input_r[0] <= ~vrd_sync0_r[2];
            if (vrd_sync1_r[1] == vrd_sync1_r[2])
                regulator_hot_input_r[1] <= ~vrd_sync1_r[2];
        end
    end

    // Over-limit state changes only on a fresh measurement
    always @(posedge clock) begin
        if (reset) begin
            phot_over_r <= 2'h0;
        end else begin
            if (processor_hot_new[0])
                phot_over_r[0] <= processor_hot_measure[7:0] > phot_limit_r; // R11
            if (processor_hot_new[1])
                phot_over_r[1] <= processor_hot_measure[15:8] > phot_limit_r; // R11
        end
    end

    // Any force cause means full
    assign force_full = (|zone_boost_active) || tach_limit_exceeded ||
                        control_r[`CTRL_FORCE_FULL_BIT]; // R5

    // ==========================================================
    // Per-channel arbitration and PWM
    genvar ch;
    generate
        for (ch = 0; ch < NUM_PWM; ch = ch + 1) begin : chan
            reg [7:0] ctrl_r;
            reg [7:0] manual_r;
            reg [7:0] bind_r;
            reg [7:0] spin_code_r;
            reg [7:0] spin_ms_r;
            reg [7:0] final_r;
            reg [7:0] spin_cnt_r;
            reg [15:0] pre_r;
            reg [7:0] phase_r;
            reg [7:0] rd_r;
            wire [7:0] auto_duty;
            wire [7:0] spin_duty;
            wire [7:0] step;
            wire [7:0] base;
            wire [7:0] forced;
            wire [7:0] other;
            wire [7:0] cand;
            wire [7:0] final_nxt;
            wire [7:0] vrd_duty;
            wire [7:0] phot_duty;
            wire vrd_act;
            wire phot_act;
            wire regulator_hot_input_bound;
            wire phot_hot_bound;
            wire alt;
            wire manual;
            wire ch_wr;
            wire [31:0] pre_limit;

            assign alt = ctrl_r[`CHCTRL_ALT_BIT]; // R2
            assign manual = ctrl_r[`CHCTRL_MANUAL_BIT];
            assign ch_wr = reg_write && reg_addr[7:4] == `CH_BASE_NIBBLE &&
                           reg_addr[3] == ch;

            // Channel register writes
            always @(posedge clock) begin
                if (reset) begin
                    ctrl_r <= `RST_CH_CTRL;
                    manual_r <= `RST_MANUAL_DUTY;
                    bind_r <= `RST_BIND;
                    spin_code_r <= `RST_SPIN_CODE;
                    spin_ms_r <= `RST_SPIN_MS;
                end else if (ch_wr) begin
                    case (reg_addr[2:0])
                        `CH_CTRL: ctrl_r <= reg_wdata;
                        `CH_MANUAL_DUTY: manual_r <= reg_wdata;
                        `CH_BIND: bind_r <= reg_wdata;
                        `CH_SPIN_CODE: spin_code_r <= reg_wdata;
                        `CH_SPIN_MS: spin_ms_r <= reg_wdata;
                        default: ctrl_r <= ctrl_r;
                    endcase
                end
            end

            // Step codes share the channel mapping
            duty_code_map auto_map (
                .code(auto_step[4*ch+3:4*ch]),
                .alternate(alt),
                .duty(auto_duty),
                .step(step)
            );
            duty_code_map spin_map (
                .code(spin_code_r[3:0]),
                .alternate(alt),
                .duty(spin_duty),
                .step()
            );

            // Bindings pick hot sources
            assign regulator_hot_input_bound = |(regulator_hot_input_r &
                bind_r[`BIND_VRD_MSB:`BIND_VRD_LSB]); // R10
            assign phot_hot_bound = |(phot_over_r &
                bind_r[`BIND_PHOT_MSB:`BIND_PHOT_LSB]); // R12

            // Ramps see the other functions except each other, no loop
            assign forced = force_full ? `DUTY_FULL : `DUTY_ZERO;
            assign base = manual ? manual_r
                : max8(spin_cnt_r != 8'h00 ? spin_duty : `DUTY_ZERO,
                       auto_duty); // R13
            assign other = max8(forced, base);

            fan_ramp vrd_ramp (
                .clock(clock),
                .reset(reset),
                .ms_tick(ms_tick_r),
                .interval_ms(ramp_ms_r),
                .hot(regulator_hot_input_bound),
                .other_duty(other),
                .step(step),
                .active_r(vrd_act),
                .ramp_duty_r(vrd_duty)
            );
            fan_ramp phot_ramp (
                .clock(clock),
                .reset(reset),
                .ms_tick(ms_tick_r),
                .interval_ms(ramp_ms_r),
                .hot(phot_hot_bound),
                .other_duty(other),
                .step(step),
                .active_r(phot_act),
                .ramp_duty_r(phot_duty)
            );

            // Priority combination by maximum
            assign cand = max8(max8(other, vrd_act ? vrd_duty : `DUTY_ZERO),
                               phot_act ? phot_duty : `DUTY_ZERO); // R4
            assign final_nxt = cand;

            // Final duty and spin-up timer
            always @(posedge clock) begin
                if (reset) begin
                    final_r <= `DUTY_ZERO;
                    spin_cnt_r <= 8'h00;
                end else begin
                    final_r <= final_nxt;
                    if (final_r == `DUTY_ZERO && final_nxt != `DUTY_ZERO &&
                        spin_cnt_r == 8'h00)
                        spin_cnt_r <= spin_ms_r; // R14
                    else if (ms_tick_r && spin_cnt_r != 8'h00)
                        spin_cnt_r <= spin_cnt_r - 8'h01; // R14
                end
            end

            // Step prescaler, power-of-two rates
            assign pre_limit = (32'h00000001 << ctrl_r[`CHCTRL_FSEL_MSB:
                `CHCTRL_FSEL_LSB]) * `PWM_STEP_CYCLES; // R1

            // Waveform; full duty holds the output high throughout
            always @(posedge clock) begin
                if (reset) begin
                    pre_r <= 16'h0000;
                    phase_r <= 8'h00;
                    fan_pwm_output[ch] <= 1'b0;
                end else begin
                    if (pre_r + 16'h0001 >= pre_limit) begin
                        pre_r <= 16'h0000;
                        if (phase_r >= `PWM_PERIOD_STEPS - 1)
                            phase_r <= 8'h00;
                        else
                            phase_r <= phase_r + 8'h01;
                    end else begin
                        pre_r <= pre_r + 16'h0001;
                    end
                    fan_pwm_output[ch] <= (final_r == `DUTY_FULL) ||
                                          (phase_r < final_r); // R1
                end
            end

            // Channel read mux
            always @* begin
                rd_r = 8'h00;
                case (reg_addr[2:0])
                    `CH_CTRL: rd_r = ctrl_r;
                    `CH_MANUAL_DUTY: rd_r = manual_r;
                    `CH_BIND: rd_r = bind_r;
                    `CH_SPIN_CODE: rd_r = spin_code_r;
                    `CH_SPIN_MS: rd_r = spin_ms_r;
                    `CH_FINAL_DUTY: rd_r = final_r;
                    default: rd_r = 8'h00;
                endcase
            end
            assign ch_rd_bus[8*ch+7:8*ch] = rd_r;
        end
    endgenerate

    // ==========================================================
    // Read data, one cycle only
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata_r <= 8'h00;
        end else if (!reg_read) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_addr[7:4] == `CH_BASE_NIBBLE &&
                     reg_addr[3] < NUM_PWM) begin
            reg_rdata_r <= ch_rd_bus[8*reg_addr[3] +: 8];
        end else begin
            case (reg_addr)
                `REG_CONTROL: reg_rdata_r <= control_r;
                `REG_RAMP_MS: reg_rdata_r <= ramp_ms_r;
                `REG_PHOT_LIMIT: reg_rdata_r <= phot_limit_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end
    end

endmodule // fan_pwm_duty_arbitration
`default_nettype wire

// ==== fan_pwm_consts.vh ====
`ifndef FAN_PWM_CONSTS_VH
`define FAN_PWM_CONSTS_VH

// ==========================================================
// Clock and timing
`define CLOCK_HZ 200000000
`define PWM_FREQ_HZ 22500
`define PWM_PERIOD_STEPS 255
`define PWM_STEP_CYCLES (`CLOCK_HZ / (`PWM_FREQ_HZ * `PWM_PERIOD_STEPS))
`define MS_PER_S 1000
`define MS_CYCLES (`CLOCK_HZ / `MS_PER_S)

// ==========================================================
// Duty encoding
`define DUTY_ZERO 8'h00
`define DUTY_FULL 8'hff
`define STEP_NORMAL 8'h14
`define STEP_ALTERNATE 8'h09

// ==========================================================
// Global register offsets
`define REG_CONTROL 8'h00
`define REG_RAMP_MS 8'h01
`define REG_PHOT_LIMIT 8'h02
`define CTRL_FORCE_FULL_BIT 0

// ==========================================================
// Per-channel register block
`define CH_BASE_NIBBLE 4'h1
`define CH_CTRL 3'h0
`define CH_MANUAL_DUTY 3'h1
`define CH_BIND 3'h2
`define CH_SPIN_CODE 3'h3
`define CH_SPIN_MS 3'h4
`define CH_FINAL_DUTY 3'h5
`define CHCTRL_MANUAL_BIT 0
`define CHCTRL_ALT_BIT 1
`define CHCTRL_FSEL_LSB 2
`define CHCTRL_FSEL_MSB 4
`define BIND_VRD_LSB 0
`define BIND_VRD_MSB 1
`define BIND_PHOT_LSB 2
`define BIND_PHOT_MSB 3

// ==========================================================
// Reset values
`define RST_CONTROL 8'h00
`define RST_RAMP_MS 8'h0a
`define RST_PHOT_LIMIT 8'h50
`define RST_CH_CTRL 8'h00
`define RST_MANUAL_DUTY 8'h00
`define RST_BIND 8'h05
`define RST_SPIN_CODE 8'h0d
`define RST_SPIN_MS 8'h64

`endif

// ==== duty_code_map.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_consts.vh"

// ==========================================================
// Step code to duty
module duty_code_map (
    // Code and mapping select
    input wire [3:0] code,
    input wire alternate,
    // Duty and step
    output reg [7:0] duty,
    output wire [7:0] step
);

    // Reserved codes fall back to full duty, the safe side for a fan
    always @* begin
        duty = `DUTY_FULL;
        if (alternate) begin
            case (code) // R3
                4'h0: duty = 8'h00;
                4'h1: duty = 8'h40;
                4'h2: duty = 8'h49;
                4'h3: duty = 8'h52;
                4'h4: duty = 8'h5b;
                4'h5: duty = 8'h64;
                4'h6: duty = 8'h6d;
                4'h7: duty = 8'h76;
                4'h8: duty = 8'h80;
                4'h9: duty = 8'h89;
                4'ha: duty = 8'h92;
                4'hb: duty = 8'hb6;
                4'hc: duty = 8'hdb;
                4'hd: duty = 8'hff;
                default: duty = `DUTY_FULL;
            endcase
        end else begin
            // Linear, 13 and up full
            if (code < 4'hd)
                duty = 8'h14 * {4'h0, code};
            else
                duty = `DUTY_FULL;
        end
    end

    // Step follows the selected mapping
    assign step = alternate ? `STEP_ALTERNATE : `STEP_NORMAL; // R15

endmodule // duty_code_map
`default_nettype wire

// ==== fan_ramp.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_consts.vh"

// ==========================================================
// One hot ramp
module fan_ramp (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Timing
    input wire ms_tick,
    input wire [7:0] interval_ms,
    // Condition and reference
    input wire hot,
    input wire [7:0] other_duty,
    input wire [7:0] step,
    // Request
    output reg active_r,
    output reg [7:0] ramp_duty_r
);

    reg [7:0] ms_cnt_r;
    wire [8:0] up_sum;
    wire [7:0] up_sat;
    wire [7:0] other_up_sat;
    wire [7:0] down_sat;
    wire [8:0] other_sum;
    wire interval_done;

    // Saturating arithmetic
    assign up_sum = {1'b0, ramp_duty_r} + {1'b0, step};
    assign up_sat = up_sum[8] ? `DUTY_FULL : up_sum[7:0]; // R7
    assign other_sum = {1'b0, other_duty} + {1'b0, step};
    assign other_up_sat = other_sum[8] ? `DUTY_FULL : other_sum[7:0];
    assign down_sat = (ramp_duty_r > step) ? ramp_duty_r - step
                                           : `DUTY_ZERO; // R15
    // An interval of zero behaves as one millisecond
    assign interval_done = ms_tick && (ms_cnt_r + 8'h01 >= interval_ms);

    // Ramp state
    always @(posedge clock) begin
        if (reset) begin
            active_r <= 1'b0;
            ramp_duty_r <= `DUTY_ZERO;
            ms_cnt_r <= 8'h00;
        end else if (!active_r) begin
            // Only a retired ramp may capture again
            if (hot) begin // R9
                active_r <= 1'b1; // R6
                ramp_duty_r <= other_up_sat; // R6
                ms_cnt_r <= 8'h00;
            end
        end else if (!hot && ramp_duty_r < other_duty) begin
            active_r <= 1'b0; // R8
            ramp_duty_r <= `DUTY_ZERO;
            ms_cnt_r <= 8'h00;
        end else if (ms_tick) begin
            if (interval_done) begin
                ms_cnt_r <= 8'h00;
                ramp_duty_r <= hot ? up_sat : down_sat; // R7 R8
            end else begin
                ms_cnt_r <= ms_cnt_r + 8'h01;
            end
        end
    end

endmodule // fan_ramp
`default_nettype wire

// ==== duty_code_map_unused_guard.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== fan_pwm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker
module fan_pwm_monitor #(
    parameter NUM_PWM = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata_r,
    // Force causes
    input wire logic [3:0] zone_boost_active,
    input wire logic tach_limit_exceeded,
    // Fan drive
    input wire logic [NUM_PWM-1:0] fan_pwm_output
);
    // One domain, one default clock and reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // Zone or tach force
    wire force_in = (|zone_boost_active) | tach_limit_exceeded;

    // ==========================================================
    // Forced full drive and read port
    a_zone_full_drive: assert property (
        (|zone_boost_active) |-> ##2 (&fan_pwm_output))
        else $error("zone force not full");
    a_tach_full_drive: assert property (
        tach_limit_exceeded |-> ##2 (&fan_pwm_output))
        else $error("tach force not full");
    a_bit_full_drive: assert property (
        reg_write && reg_addr == 8'h00 && reg_wdata[0]
        |-> ##3 (&fan_pwm_output))
        else $error("override not full");
    a_final_forced_ch0: assert property (
        $past(force_in) && reg_read && reg_addr == 8'h15
        |=> reg_rdata_r == 8'hff)
        else $error("ch0 duty not full");
    a_final_forced_ch1: assert property (
        $past(force_in) && reg_read && reg_addr == 8'h1d
        |=> reg_rdata_r == 8'hff)
        else $error("ch1 duty not full");
    a_rdata_idle_zero: assert property (
        !reg_read |=> reg_rdata_r == 8'h00)
        else $error("read data not idle");
    a_unmapped_read_zero: assert property (
        reg_read && reg_addr == 8'h30 |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_reset_quiet_out: assert property (
        $fell(reset) |-> fan_pwm_output == '0 && reg_rdata_r == 8'h00)
        else $error("outputs busy after reset");
endmodule // fan_pwm_monitor

`default_nettype wire

// ==== fan_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Fan stage: period and high time
module fan_stage_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Drive from the block
    input wire logic drive,
    // Last full period
    output var logic [31:0] period_cyc,
    output var logic [31:0] high_cyc,
    output var logic [31:0] n_meas
);
    logic [31:0] per_cnt;
    logic [31:0] high_cnt;
    logic drive_d;
    logic armed;

    // First rise only arms, no partial period
    always @(posedge clock) begin
        if (reset) begin
            period_cyc <= '0;
            high_cyc <= '0;
            n_meas <= '0;
            per_cnt <= '0;
            high_cnt <= '0;
            drive_d <= 1'b0;
            armed <= 1'b0;
        end else begin
            drive_d <= drive;
            if (drive && !drive_d) begin
                if (armed) begin
                    period_cyc <= per_cnt;
                    high_cyc <= high_cnt;
                    n_meas <= n_meas + 32'h1;
                end
                armed <= 1'b1;
                per_cnt <= 32'h1;
                high_cnt <= 32'h1;
            end else begin
                per_cnt <= per_cnt + 32'h1;
                high_cnt <= high_cnt + {31'h0, drive};
            end
        end
    end
endmodule // fan_stage_model

`default_nettype wire

// ==== fan_pwm_duty_arbitration_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench
module fan_pwm_duty_arbitration_tb;
    // Reset table: address high byte, value low byte
    localparam [223:0] RST = {16'h3000, 16'h1c64, 16'h1b0d, 16'h1a05,
        16'h1900, 16'h1800, 16'h1464, 16'h130d, 16'h1205, 16'h1100,
        16'h1000, 16'h0250, 16'h010a, 16'h0000};
    // Alternate duties, codes 0 to 13
    localparam [111:0] ALT = {8'hff, 8'hdb, 8'hb6, 8'h92, 8'h89, 8'h80,
        8'h76, 8'h6d, 8'h64, 8'h5b, 8'h52, 8'h49, 8'h40, 8'h00};
    logic clock, reset, reg_write, reg_read, tach_limit_exceeded;
    logic [7:0] reg_addr, reg_wdata, auto_step;
    logic [3:0] zone_boost_active, c1;
    logic [1:0] regulator_hot_input_n, processor_hot_new;
    logic [15:0] processor_hot_measure;
    wire [7:0] reg_rdata_r;
    wire [1:0] fan_pwm_output;
    wire [31:0] per, hi, nm;
    integer fails, n_tests, cycles, seed, i, c, a;

    fan_pwm_duty_arbitration #(.NUM_PWM(2), .MS_CYCLES(20)) dut_u (
        .clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_r(reg_rdata_r), .zone_boost_active(zone_boost_active),
        .tach_limit_exceeded(tach_limit_exceeded),
        .regulator_hot_input_n(regulator_hot_input_n),
        .processor_hot_measure(processor_hot_measure),
        .processor_hot_new(processor_hot_new), .auto_step(auto_step),
        .fan_pwm_output(fan_pwm_output));
    fan_stage_model fan_u (.clock(clock), .reset(reset),
        .drive(fan_pwm_output[0]), .period_cyc(per), .high_cyc(hi),
        .n_meas(nm));

    // ==========================================================
    // Tasks
    function [7:0] map_duty(input [3:0] code, input alt);
        if (alt)
            map_duty = ALT[code*8 +: 8];
        else
            map_duty = (code > 4'd12) ? 8'hff : code * 8'd20;
    endfunction
    task same(input [31:0] g, input [31:0] e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input [7:0] a_i, input [7:0] d_i);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a_i;
        reg_wdata <= d_i;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Data stand only the cycle after
    task chk(input [7:0] a_i, input [7:0] e_i);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a_i;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        same({24'h0, reg_rdata_r}, {24'h0, e_i});
    endtask
    // Skip the period cut by a change
    task measure(input [31:0] ep, input [31:0] eh);
        a = nm;
        while (nm < a + 2)
            @(posedge clock);
        #1;
        same(per, ep);
        same(hi, eh);
    endtask
    task wait_n(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 95000) begin
            fails = fails + 1;
            $display("[FAIL] %0t timeout", $time);
            results;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = 85963;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        reset = 1'b1;
        {reg_write, reg_read, tach_limit_exceeded} = 3'b000;
        {reg_addr, reg_wdata, auto_step} = 24'h0;
        zone_boost_active = 4'h0;
        regulator_hot_input_n = 2'b11;
        processor_hot_new = 2'b00;
        processor_hot_measure = 16'h0;
        wait_n(20);
        reset <= 1'b0;
        // Reset values, read-only duty
        for (i = 0; i < 14; i = i + 1)
            chk(RST[i*16+8 +: 8], RST[i*16 +: 8]);
        wr(8'h15, 8'h77);
        chk(8'h15, 8'h00);
        // Spin-up from zero
        wr(8'h14, 8'h03);
        @(posedge clock);
        auto_step <= 8'h02;
        wait_n(4);
        chk(8'h15, 8'hff);
        wait_n(200);
        chk(8'h15, 8'h28);
        wr(8'h13, 8'h00);
        wr(8'h1b, 8'h00);
        // Both mappings
        for (a = 0; a < 2; a = a + 1) begin
            wr(8'h10, a[0] ? 8'h02 : 8'h00);
            for (c = 0; c < 14; c = c + 1) begin
                c1 = 4'({$random(seed)} % 13);
                @(posedge clock);
                auto_step <= {c1, c[3:0]};
                wait_n(3);
                chk(8'h15, map_duty(c[3:0], a[0]));
                chk(8'h1d, map_duty(c1, 1'b0));
            end
        end
        // Manual against forced
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h40);
        @(posedge clock);
        auto_step <= 8'h0c;
        wait_n(3);
        chk(8'h15, 8'h40);
        @(posedge clock);
        zone_boost_active <= 4'({$random(seed)} % 15 + 1);
        wait_n(3);
        chk(8'h15, 8'hff);
        chk(8'h1d, 8'hff);
        @(posedge clock);
        zone_boost_active <= 4'h0;
        tach_limit_exceeded <= 1'b1;
        wait_n(3);
        chk(8'h15, 8'hff);
        @(posedge clock);
        tach_limit_exceeded <= 1'b0;
        wr(8'h00, 8'h01);
        chk(8'h1d, 8'hff);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h00);
        chk(8'h15, 8'hf0);
        // Waveform, two rates
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h80);
        measure(32'd8670, 32'd4352);
        wr(8'h10, 8'h05);
        measure(32'd17340, 32'd8704);
        // Regulator ramp, ch0
        wr(8'h10, 8'h00);
        wr(8'h1a, 8'h08);
        wr(8'h01, 8'd50);
        c1 = 4'({$random(seed)} % 13);
        @(posedge clock);
        auto_step <= {c1, 4'h3};
        wait_n(3);
        regulator_hot_input_n <= 2'b10;
        wait_n(10);
        chk(8'h15, 8'h50);
        chk(8'h1d, map_duty(c1, 1'b0));
        wr(8'h01, 8'h05);
        wait_n(1500);
        chk(8'h15, 8'hff);
        regulator_hot_input_n <= 2'b11;
        wait_n(1500);
        chk(8'h15, 8'h3c);
        // Processor ramp, alternate
        wr(8'h10, 8'h02);
        wr(8'h01, 8'd50);
        processor_hot_measure <= {8'h3f & 8'($random(seed)), 8'h60};
        processor_hot_new <= 2'b11;
        @(posedge clock);
        processor_hot_new <= 2'b00;
        wait_n(6);
        chk(8'h15, 8'h5b);
        chk(8'h1d, map_duty(c1, 1'b0));
        wr(8'h01, 8'h05);
        processor_hot_measure <= {8'h20, 8'h10};
        processor_hot_new <= 2'b01;
        @(posedge clock);
        processor_hot_new <= 2'b00;
        wait_n(1500);
        chk(8'h15, 8'h52);
        results;
    end
endmodule // fan_pwm_duty_arbitration_tb

bind fan_pwm_duty_arbitration fan_pwm_monitor #(.NUM_PWM(NUM_PWM)) mon_u (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_r(reg_rdata_r), .zone_boost_active(zone_boost_active),
    .tach_limit_exceeded(tach_limit_exceeded),
    .fan_pwm_output(fan_pwm_output));

`default_nettype wire
